// File: verilog/sdpc_pkg.sv
// Purpose: constants for the step/direction position counter
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz aclk
// Notes: offsets are byte addresses of aligned words
package sdpc_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] SDPC_OFF_CTRL = 4'h0;
	localparam logic [3:0] SDPC_OFF_POS = 4'h4;
	localparam logic [3:0] SDPC_OFF_GEAR = 4'h8;
	localparam logic [3:0] SDPC_OFF_STAT = 4'hC;
	// ctrl fields
	localparam int SDPC_CTRL_SEL_BIT = 0;
	localparam int SDPC_CTRL_GEAR_BIT = 1;
	localparam int SDPC_CTRL_CLR_BIT = 2;
	// reset values and bus response codes
	localparam logic [31:0] SDPC_POS_RST = 32'h0000_0000;
	localparam logic [31:0] SDPC_GEAR_RST = 32'h0000_0001;
	localparam logic [1:0] SDPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SDPC_RESP_SLVERR = 2'h2;
	// motor direction encoding: 1 is clockwise seen at the shaft
	localparam logic SDPC_DIR_CW = 1'b1;
endpackage

// File: verilog/sdpc_top.sv
// Behaviour
// - With the select bit at 1, input one is a step and input two a direction level.
// - Each low-to-high step edge moves the count by exactly one; apart from that only the ctrl clear bit changes it.
// - A step edge with direction high increments the count.
// - A step edge with direction low decrements the count.
// - A step is taken when the isolated input turns on, so the source gives a rising edge.
// - With gearing on and a positive gear_a, direction-high steps command clockwise.
// - Input one is encoder A or step, input two is encoder B or direction.
//
// Purpose: position counter fed by step/direction or quadrature inputs
// Assumes: AXI4-Lite slave, opto inputs asynchronous to aclk
// Notes: motor step pulse and direction leave as registered outputs
`timescale 1ns/1ps
module sdpc_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// isolated inputs (on = high)
	input wire logic in_a_step,
	input wire logic in_b_dir,
	// motor command
	output logic motor_step,
	output logic motor_cw,
	// axi write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import sdpc_pkg::*;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] a_sync_r, b_sync_r;
	logic a_prev_r, b_prev_r;
	// only stage 1 is looked at; stage 0 may be metastable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_sync_r <= 2'h0;
			b_sync_r <= 2'h0;
			a_prev_r <= 1'b0;
			b_prev_r <= 1'b0;
		end else begin
			a_sync_r <= {a_sync_r[0], in_a_step};
			b_sync_r <= {b_sync_r[0], in_b_dir};
			a_prev_r <= a_sync_r[1];
			b_prev_r <= b_sync_r[1];
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic sel_r, sel_nxt, gear_on_r, gear_on_nxt;
	logic [31:0] pos_r, pos_nxt, gear_r, gear_nxt;
	logic [31:0] wdat_r, wdat_nxt, rdata_nxt;
	logic [3:0] waddr_r, waddr_nxt;
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic bvalid_nxt, rvalid_nxt, arready_nxt;
	logic [1:0] bresp_nxt, rresp_nxt;
	logic step_nxt, cw_nxt, up, dn, clr;
	logic [3:0] wstrb_r, wstrb_nxt;

	// byte-lane merge, used for the gear word only; ctrl takes byte lane 0 alone
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// ----------------------------------------------------------------
	// count decode
	// ----------------------------------------------------------------
	always_comb begin
		up = 1'b0;
		dn = 1'b0;
		if (sel_r) begin
			// rising step only; direction sampled at that edge
			if (a_sync_r[1] && !a_prev_r) begin
				up = b_sync_r[1];
				dn = !b_sync_r[1];
			end
		end else begin
			// one count per edge; a double change is illegal and dropped
			case ({a_prev_r, b_prev_r, a_sync_r[1], b_sync_r[1]})
				4'h1, 4'h7, 4'hE, 4'h8: up = 1'b1;
				4'h2, 4'h4, 4'hD, 4'hB: dn = 1'b1;
				default: begin
					up = 1'b0;
					dn = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// bus and state next values
	// ----------------------------------------------------------------
	logic do_wr;
	assign do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
	always_comb begin
		sel_nxt = sel_r;
		gear_on_nxt = gear_on_r;
		gear_nxt = gear_r;
		waddr_nxt = waddr_r;
		wdat_nxt = wdat_r;
		wstrb_nxt = wstrb_r;
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		bvalid_nxt = s_axi_bvalid;
		bresp_nxt = s_axi_bresp;
		rvalid_nxt = s_axi_rvalid;
		rresp_nxt = s_axi_rresp;
		rdata_nxt = s_axi_rdata;
		arready_nxt = 1'b0;
		clr = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			waddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			wdat_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (do_wr) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = SDPC_RESP_OKAY;
			if (waddr_r[3:2] == SDPC_OFF_CTRL[3:2]) begin
				if (wstrb_r[0]) begin
					sel_nxt = wdat_r[SDPC_CTRL_SEL_BIT];
					gear_on_nxt = wdat_r[SDPC_CTRL_GEAR_BIT];
					clr = wdat_r[SDPC_CTRL_CLR_BIT];
				end
			end else if (waddr_r[3:2] == SDPC_OFF_GEAR[3:2]) begin
				gear_nxt = merge(gear_r, wdat_r, wstrb_r);
			end else if (waddr_r[3:2] != SDPC_OFF_POS[3:2]) begin
				bresp_nxt = SDPC_RESP_SLVERR;
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = SDPC_RESP_OKAY;
			if (s_axi_araddr[3:2] == SDPC_OFF_CTRL[3:2]) begin
				rdata_nxt = {30'h0, gear_on_r, sel_r};
			end else if (s_axi_araddr[3:2] == SDPC_OFF_POS[3:2]) begin
				rdata_nxt = pos_r;
			end else if (s_axi_araddr[3:2] == SDPC_OFF_GEAR[3:2]) begin
				rdata_nxt = gear_r;
			end else begin
				rdata_nxt = {30'h0, b_sync_r[1], a_sync_r[1]};
			end
		end else if (!s_axi_rvalid && !s_axi_arready) begin
			arready_nxt = s_axi_arvalid;
		end
		// a count edge in the clear cycle still lands after the clear
		if (clr) begin
			pos_nxt = SDPC_POS_RST;
		end else begin
			pos_nxt = pos_r;
		end
		if (up) begin
			pos_nxt = pos_nxt + 32'h1;
		end else if (dn) begin
			pos_nxt = pos_nxt - 32'h1;
		end
		// gear sign flips motor sense; zero gear_a issues no steps
		step_nxt = gear_on_r && (up || dn) && (gear_r != 32'h0);
		cw_nxt = motor_cw;
		if (step_nxt) begin
			cw_nxt = (up ^ gear_r[31]) ? SDPC_DIR_CW : !SDPC_DIR_CW;
		end
	end

	// registers only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_r <= 1'b0;
			gear_on_r <= 1'b0;
			gear_r <= SDPC_GEAR_RST;
			pos_r <= SDPC_POS_RST;
			waddr_r <= 4'h0;
			wdat_r <= 32'h0;
			wstrb_r <= 4'h0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0;
			s_axi_arready <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			motor_step <= 1'b0;
			motor_cw <= 1'b0;
		end else begin
			sel_r <= sel_nxt;
			gear_on_r <= gear_on_nxt;
			gear_r <= gear_nxt;
			pos_r <= pos_nxt;
			waddr_r <= waddr_nxt;
			wdat_r <= wdat_nxt;
			wstrb_r <= wstrb_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_bresp <= bresp_nxt;
			s_axi_rvalid <= rvalid_nxt;
			s_axi_rresp <= rresp_nxt;
			s_axi_rdata <= rdata_nxt;
			s_axi_arready <= arready_nxt;
			// ready only while the holding slot is free
			s_axi_awready <= !aw_have_nxt && !s_axi_awready;
			s_axi_wready <= !w_have_nxt && !s_axi_wready;
			motor_step <= step_nxt;
			motor_cw <= cw_nxt;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence step_rise;
		sel_r && a_sync_r[1] && !a_prev_r && !clr;
	endsequence

	AST_STEP_UP: assert property (@(posedge aclk) disable iff (!aresetn)
		step_rise and b_sync_r[1] |=> pos_r == $past(pos_r) + 32'h1)
		else $error("step with direction high did not increment");
	AST_STEP_DN: assert property (@(posedge aclk) disable iff (!aresetn)
		step_rise and !b_sync_r[1] |=> pos_r == $past(pos_r) - 32'h1)
		else $error("step with direction low did not decrement");
	AST_NO_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
		sel_r && !(a_sync_r[1] && !a_prev_r) && !clr |=> $stable(pos_r))
		else $error("count moved without a rising step");
	AST_SEL_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
		sel_r && a_sync_r[1] && !a_prev_r |-> (up ^ dn))
		else $error("step mode did not count a rising step");
	AST_INPUT_ROLE: assert property (@(posedge aclk) disable iff (!aresetn)
		sel_r && !a_sync_r[1] |-> !up && !dn)
		else $error("direction line alone changed the count");
	AST_RISE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
		sel_r && !a_sync_r[1] && a_prev_r |-> !up && !dn)
		else $error("falling step edge was counted");
	AST_CW: assert property (@(posedge aclk) disable iff (!aresetn)
		gear_on_r && up && !gear_r[31] && gear_r != 32'h0
		|=> motor_step && motor_cw == SDPC_DIR_CW)
		else $error("positive gear_a direction-high step not clockwise");
	AST_QUAD: assert property (@(posedge aclk) disable iff (!aresetn)
		!sel_r && !clr && a_sync_r[1] != a_prev_r && b_sync_r[1] != b_prev_r
		|=> $stable(pos_r))
		else $error("illegal quadrature double change was counted");

	// one input changed alone; direction taken from the phase order
	sequence quad_single;
		!sel_r && !clr
		&& ((a_sync_r[1] != a_prev_r) != (b_sync_r[1] != b_prev_r));
	endsequence

	// old A differing from new B means forward in 00 01 11 10
	AST_QUAD_UP: assert property (
		@(posedge aclk) disable iff (!aresetn)
		quad_single ##0 (a_prev_r ^ b_sync_r[1])
		|=> pos_r == $past(pos_r) + 32'h1)
		else $error("quadrature forward edge did not increment");
	AST_QUAD_DN: assert property (
		@(posedge aclk) disable iff (!aresetn)
		quad_single ##0 !(a_prev_r ^ b_sync_r[1])
		|=> pos_r == $past(pos_r) - 32'h1)
		else $error("quadrature reverse edge did not decrement");
	// negative gear_a turns the motor the other way
	AST_CCW: assert property (
		@(posedge aclk) disable iff (!aresetn)
		gear_on_r && up && gear_r[31]
		|=> motor_step && motor_cw == !SDPC_DIR_CW)
		else $error("negative gear_a step not reversed");
	// zero gear_a must never step the motor
	AST_ZERO_GEAR: assert property (
		@(posedge aclk) disable iff (!aresetn)
		gear_r == 32'h0 |=> !motor_step)
		else $error("motor stepped with zero gear_a");
endmodule

// File: bench/sdpc_src.sv
// Purpose: pulse source model driving the two isolated inputs
// Assumes: one command per req, every level held at least 3 cycles
// Notes: quadrature phase order 00 01 11 10 counts up
`timescale 1ns/1ps
module sdpc_src (
	// control from bench
	input wire logic aclk,
	input wire logic quad,
	input wire logic req,
	input wire logic up,
	output logic busy,
	// isolated lines, high means opto on
	output logic in_a_step,
	output logic in_b_dir
);
	logic [1:0] ph;
	// ----------------------------------------------------------------
	// pulse generation
	// ----------------------------------------------------------------
	// direction settles well before the step edge, so no race
	initial begin
		busy = 1'b0;
		in_a_step = 1'b0;
		in_b_dir = 1'b0;
		ph = 2'h0;
		forever begin
			@(posedge aclk);
			if (req) begin
				busy <= 1'b1;
				if (quad) begin
					ph = up ? ph + 2'h1 : ph - 2'h1;
					in_a_step <= ph[1];
					in_b_dir <= ph[1] ^ ph[0];
					repeat (4) @(posedge aclk);
				end else begin
					in_b_dir <= up;
					repeat (3) @(posedge aclk);
					in_a_step <= 1'b1;
					repeat (3) @(posedge aclk);
					in_a_step <= 1'b0;
					repeat (3) @(posedge aclk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule

// File: bench/sdpc_top_tb.sv
// Purpose: self-checking bench for the position counter
// Assumes: pulse source model on the isolated inputs
// Notes: bus handshakes sampled at the rising edge that completes them
`timescale 1ns/1ps
module sdpc_top_tb;
	import sdpc_pkg::*;
	logic aclk, aresetn, in_a_step, in_b_dir, motor_step, motor_cw;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, quad, req, up, busy, mcw;
	int bad_count, num_checks, cyc, mcnt, m0;

	sdpc_top sdpc_top_inst (.aclk, .aresetn, .in_a_step, .in_b_dir,
		.motor_step, .motor_cw, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	sdpc_src sdpc_src_inst (.aclk, .quad, .req, .up, .busy, .in_a_step,
		.in_b_dir);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			bad_count++;
		end
	endtask

	// address and data offered together, each dropped once taken
	// waits as long as it takes; only the hang guard ends a stuck wait
	task automatic axw(input logic [3:0] ad, input logic [31:0] d,
		input logic [1:0] er);
		logic done;
		logic [1:0] r;
		done = 1'b0;
		r = 2'h0;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask

	// data and response taken at the edge where rvalid is seen
	task automatic axr(input logic [3:0] ad, output logic [31:0] d);
		logic done;
		logic [1:0] r;
		done = 1'b0;
		r = 2'h3;
		d = 32'h0;
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
		chk("rresp", {30'h0, SDPC_RESP_OKAY}, {30'h0, r});
	endtask

	// extra wait covers the two sync flops and the count update
	task automatic pulse(input logic q, input logic u, input int n);
		repeat (n) begin
			@(posedge aclk);
			quad <= q;
			up <= u;
			req <= 1'b1;
			@(posedge aclk);
			req <= 1'b0;
			for (int i = 0; i < 20; i++) begin
				@(posedge aclk);
				if (!busy) break;
			end
		end
		repeat (4) @(posedge aclk);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, motor monitor and hang guard
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (motor_step === 1'b1) begin
			mcnt++;
			mcw = motor_cw;
		end
		if (cyc == 20000) begin
			bad_count++;
			final_report;
		end
	end

	// main sequence
	initial begin
		{aresetn, quad, req, up, s_axi_awvalid, s_axi_wvalid} = 6'h00;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hF;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axr(SDPC_OFF_POS, rd);
		chk("pos reset", SDPC_POS_RST, rd);
		axr(SDPC_OFF_GEAR, rd);
		chk("gear reset", SDPC_GEAR_RST, rd);
		$display("test reset done");
		axw(SDPC_OFF_CTRL, 32'h1, SDPC_RESP_OKAY);
		pulse(1'b0, 1'b1, 3);
		axr(SDPC_OFF_POS, rd);
		chk("pos up", 32'h3, rd);
		axw(SDPC_OFF_CTRL, 32'h3, SDPC_RESP_OKAY);
		axr(SDPC_OFF_CTRL, rd);
		chk("ctrl", 32'h3, rd);
		m0 = mcnt;
		pulse(1'b0, 1'b1, 2);
		chk("motor steps", m0 + 2, mcnt);
		chk("motor cw", {31'h0, SDPC_DIR_CW}, {31'h0, mcw});
		pulse(1'b0, 1'b0, 7);
		axr(SDPC_OFF_POS, rd);
		chk("pos down", 32'hFFFF_FFFE, rd);
		// negative gear_a reverses the motor, zero gear_a silences it
		axw(SDPC_OFF_GEAR, 32'hFFFF_FFFF, SDPC_RESP_OKAY);
		axr(SDPC_OFF_GEAR, rd);
		chk("gear", 32'hFFFF_FFFF, rd);
		m0 = mcnt;
		pulse(1'b0, 1'b1, 1);
		chk("motor steps neg", m0 + 1, mcnt);
		chk("motor ccw", {31'h0, !SDPC_DIR_CW}, {31'h0, mcw});
		axw(SDPC_OFF_GEAR, 32'h0, SDPC_RESP_OKAY);
		// direction left low so quadrature starts from phase 00
		pulse(1'b0, 1'b0, 1);
		chk("motor steps zero", m0 + 1, mcnt);
		axr(SDPC_OFF_POS, rd);
		chk("pos gear", 32'hFFFF_FFFE, rd);
		$display("test step dir done");
		axw(SDPC_OFF_CTRL, 32'h4, SDPC_RESP_OKAY);
		pulse(1'b1, 1'b1, 4);
		axr(SDPC_OFF_POS, rd);
		chk("quad up", 32'h4, rd);
		pulse(1'b1, 1'b0, 1);
		axr(SDPC_OFF_POS, rd);
		chk("quad down", 32'h3, rd);
		axr(SDPC_OFF_STAT, rd);
		chk("status", 32'h1, rd);
		$display("test quadrature done");
		axw(SDPC_OFF_STAT, 32'h0, SDPC_RESP_SLVERR);
		axw(SDPC_OFF_POS, 32'h55, SDPC_RESP_OKAY);
		axr(SDPC_OFF_POS, rd);
		chk("pos read only", 32'h3, rd);
		$display("test access done");
		final_report;
	end
endmodule
